/* core/trf_pkg.sv */
// Shared constants, carriers and state layout for the result/alarm block
package trf_pkg;

    // ****************************************************************
    // Register offsets on the plain register port
    // ****************************************************************
    localparam logic [3:0] TRF_ADDR_CFG = 4'h0;
    localparam logic [3:0] TRF_ADDR_HYST = 4'h1;
    localparam logic [3:0] TRF_ADDR_CONSEC = 4'h2;
    localparam logic [3:0] TRF_ADDR_STATUS = 4'h3;
    localparam logic [3:0] TRF_ADDR_LOC_HI = 4'h4;
    localparam logic [3:0] TRF_ADDR_LOC_LO = 4'h5;
    localparam logic [3:0] TRF_ADDR_REM_HI = 4'h6;
    localparam logic [3:0] TRF_ADDR_REM_LO = 4'h7;
    localparam logic [3:0] TRF_ADDR_LOC_HLIM = 4'h8;
    localparam logic [3:0] TRF_ADDR_LOC_LLIM = 4'h9;
    localparam logic [3:0] TRF_ADDR_REM_HLIM = 4'ha;
    localparam logic [3:0] TRF_ADDR_REM_LLIM = 4'hb;
    localparam logic [3:0] TRF_ADDR_LOC_OLIM = 4'hc;
    localparam logic [3:0] TRF_ADDR_REM_OLIM = 4'hd;
    localparam logic [3:0] TRF_ADDR_PINS = 4'he;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int TRF_CFG_MASK = 7;
    localparam int TRF_CFG_PWRDN = 6;
    localparam int TRF_CFG_FSEL = 5;
    localparam int TRF_CFG_RANGE = 2;
    localparam int TRF_ST_LOC_HIGH = 6;
    localparam int TRF_ST_LOC_LOW = 5;
    localparam int TRF_ST_REM_HIGH = 4;
    localparam int TRF_ST_REM_LOW = 3;
    localparam int TRF_ST_OPEN = 2;

    // ****************************************************************
    // Reset values and format constants
    // ****************************************************************
    localparam logic [7:0] TRF_CFG_RST = 8'h00;
    localparam logic [7:0] TRF_HYST_RST = 8'h0a;
    localparam logic [7:0] TRF_HLIM_RST = 8'h55;
    localparam logic [7:0] TRF_LLIM_RST = 8'h00;
    localparam logic [7:0] TRF_OLIM_RST = 8'h55;
    localparam logic [1:0] TRF_CONSEC_RST = 2'h0;
    localparam logic signed [9:0] TRF_EXT_OFFSET = 10'sh040;
    localparam logic signed [9:0] TRF_STD_MAX = 10'sh07f;
    localparam logic signed [9:0] TRF_EXT_MAX = 10'sh0ff;
    localparam logic [2:0] TRF_CNT_MAX = 3'h4;
    localparam logic TRF_CH_LOCAL = 1'b0;
    localparam logic TRF_CH_REMOTE = 1'b1;

    typedef enum logic [1:0] {TRF_IDLE, TRF_BETA, TRF_CONV} trf_phase_t;

    // Register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } trf_bus_t;

    // Conversion result from the front end, temp in signed sixteenths
    typedef struct packed {
        logic done;
        logic fault;
        logic signed [12:0] temp;
    } trf_conv_t;

    typedef struct packed {
        trf_phase_t phase;
        logic chan;
        logic range_ext;
        logic [7:0] cfg;
        logic [7:0] hyst;
        logic [1:0] consec;
        logic [7:0] status;
        logic [1:0][7:0] res_hi;
        logic [1:0][7:0] res_lo;
        logic [1:0][7:0] hlim;
        logic [1:0][7:0] llim;
        logic [1:0][7:0] olim;
        logic [1:0][2:0] cnt;
        logic [1:0] ol_act;
        logic [1:0] ol2_act;
        logic open_live;
        logic alert;
        logic [7:0] rdata;
        logic conv_start;
        logic beta_start;
        logic conv_abort;
        logic ol_oe_n;
        logic al_oe_n;
    } trf_state_t;

    localparam trf_state_t TRF_STATE_RST = '{
        phase: TRF_IDLE, chan: TRF_CH_REMOTE, cfg: TRF_CFG_RST,
        hyst: TRF_HYST_RST, consec: TRF_CONSEC_RST,
        hlim: {2{TRF_HLIM_RST}}, llim: {2{TRF_LLIM_RST}},
        olim: {2{TRF_OLIM_RST}}, ol_oe_n: 1'b1, al_oe_n: 1'b1,
        default: '0};

endpackage

/* core/trf_core.sv */
// Temperature result formatting, conversion sequencing and alarm pins
//
// The register offsets and the plain strobed port were left to the implementer.

// What this block does
// - Standard range high byte clamps below zero to 00 and above 127 to 7f.
// - Config bit 2 high selects extended range and extended binary format.
// - Range change applies from the next conversion; stored results keep format.
// - Extended range adds 64 to the high byte, covering -64 to 191.
// - Each result is two bytes: whole degrees high, fraction low.
// - Low byte holds sixteenths in its upper nibble, lower nibble zero.
// - Every remote conversion starts with current range selection.
// - Remote fault keeps last result, sets open bit 2, alerts if enabled.
// - Over-limit flag pulls low when a channel exceeds its flag limit.
// - Over-limit flag cannot be disabled by software.
// - Over-limit flag releases once at or below limit minus hysteresis.
// - Hysteresis resets to ten degrees.
// - Shared pin defaults to alert function, select bit clear.
// - Select bit 5 set makes shared pin a second over-limit flag on high limits.
// - Alert mode pulls low on high or low limit violation.
// - Alert needs one to four consecutive violating conversions.
// - Config bit 7 masks the alert so it never drives low.
// - Host address read releases alert only if condition ended and status clear.
// - Both alarm outputs are open-drain, drive low only.
// - Shutdown bit aborts the conversion at once; clear means continuous.
module trf_core
    import trf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire trf_bus_t bus,
    output logic [7:0] rdata,
    input wire trf_conv_t conv,
    input wire logic beta_done,
    input wire logic alert_resp,
    output logic conv_start,
    output logic conv_chan,
    output logic beta_start,
    output logic conv_abort,
    input wire logic over_limit_flag_in,
    output logic over_limit_flag_o,
    output logic over_limit_flag_oe_n,
    input wire logic alarm_pin_in,
    output logic alarm_pin_o,
    output logic alarm_pin_oe_n
);

    // ****************************************************************
    // Result formatting
    // ****************************************************************

    // Clamp to the selected range; clamped values drop their fraction
    function automatic logic [15:0] trf_format(
        input logic signed [12:0] raw,
        input logic ext
    );
        logic signed [9:0] whole;
        logic signed [9:0] top;
        whole = 10'(raw >>> 4);
        top = TRF_STD_MAX;
        if (ext) begin
            whole = 10'(whole + TRF_EXT_OFFSET);
            top = TRF_EXT_MAX;
        end
        if (whole < 10'sh000) begin
            trf_format = 16'h0000;
        end else if (whole > top) begin
            trf_format = {top[7:0], 8'h00};
        end else begin
            trf_format = {whole[7:0], raw[3:0], 4'h0};
        end
    endfunction

    trf_state_t st;
    trf_state_t next_st;
    logic [15:0] fmt;
    logic [7:0] hi;
    logic store_ok;
    logic store_fault;
    logic [1:0] next_ol;
    logic [1:0] next_ol2;
    logic [1:0][2:0] next_cnt;
    logic [1:0] qual;
    logic [1:0] set_hi;
    logic [1:0] set_lo;
    logic [1:0] live;

    // Format uses the range caught at conversion start, not live config
    assign fmt = trf_format(conv.temp, st.range_ext);
    assign hi = fmt[15:8];

    // A completed conversion, unless shutdown aborts it this cycle
    assign store_ok = st.phase == TRF_CONV && conv.done && !conv.fault
        && !st.cfg[TRF_CFG_PWRDN];
    assign store_fault = st.phase == TRF_CONV && conv.done && conv.fault
        && !st.cfg[TRF_CFG_PWRDN] && st.chan == TRF_CH_REMOTE;

    // ****************************************************************
    // Per-channel limit evaluation
    // ****************************************************************
    for (genvar c = 0; c < 2; c++) begin : g_chan
        logic upd;
        logic viol;
        logic [7:0] ol_thr;
        logic [7:0] ol2_thr;

        assign upd = store_ok && st.chan == 1'(c);
        // Saturate so a small limit never wraps the release point
        assign ol_thr = st.olim[c] > st.hyst ? 8'(st.olim[c] - st.hyst)
            : 8'h00;
        assign ol2_thr = st.hlim[c] > st.hyst ? 8'(st.hlim[c] - st.hyst)
            : 8'h00;

        // Assert above the limit, hold until at or below limit minus hysteresis
        assign next_ol[c] = !upd ? st.ol_act[c]
            : st.ol_act[c] ? hi > ol_thr : hi > st.olim[c];
        assign next_ol2[c] = !upd ? st.ol2_act[c]
            : st.ol2_act[c] ? hi > ol2_thr : hi > st.hlim[c];

        assign viol = hi > st.hlim[c] || hi < st.llim[c];
        // Consecutive count, saturating so it cannot wrap to zero
        assign next_cnt[c] = !upd ? st.cnt[c]
            : !viol ? 3'h0
            : st.cnt[c] == TRF_CNT_MAX ? TRF_CNT_MAX
            : 3'(st.cnt[c] + 3'h1);
        assign live[c] = next_cnt[c] > {1'b0, st.consec};
        assign qual[c] = upd && live[c];
        assign set_hi[c] = qual[c] && hi > st.hlim[c];
        assign set_lo[c] = qual[c] && hi < st.llim[c];
    end

    // ****************************************************************
    // Next-state logic
    // ****************************************************************

    // One process owns every state field; pulses default low each cycle
    always_comb begin
        next_st = st;
        next_st.conv_start = 1'b0;
        next_st.beta_start = 1'b0;
        next_st.conv_abort = 1'b0;
        next_st.rdata = 8'h00;

        // Register writes
        if (bus.wr) begin
            unique case (bus.addr)
                TRF_ADDR_CFG: next_st.cfg = bus.wdata;
                TRF_ADDR_HYST: next_st.hyst = bus.wdata;
                TRF_ADDR_CONSEC: next_st.consec = bus.wdata[1:0];
                TRF_ADDR_LOC_HLIM: next_st.hlim[0] = bus.wdata;
                TRF_ADDR_LOC_LLIM: next_st.llim[0] = bus.wdata;
                TRF_ADDR_REM_HLIM: next_st.hlim[1] = bus.wdata;
                TRF_ADDR_REM_LLIM: next_st.llim[1] = bus.wdata;
                TRF_ADDR_LOC_OLIM: next_st.olim[0] = bus.wdata;
                TRF_ADDR_REM_OLIM: next_st.olim[1] = bus.wdata;
                default: ;
            endcase
        end

        // Conversion sequencing, local and remote in turn
        unique case (st.phase)
            TRF_IDLE: begin
                if (!st.cfg[TRF_CFG_PWRDN]) begin
                    next_st.chan = ~st.chan;
                    next_st.range_ext = st.cfg[TRF_CFG_RANGE];
                    if (~st.chan == TRF_CH_REMOTE) begin
                        next_st.beta_start = 1'b1;
                        next_st.phase = TRF_BETA;
                    end else begin
                        next_st.conv_start = 1'b1;
                        next_st.phase = TRF_CONV;
                    end
                end
            end
            TRF_BETA: begin
                if (st.cfg[TRF_CFG_PWRDN]) begin
                    next_st.conv_abort = 1'b1;
                    next_st.phase = TRF_IDLE;
                end else if (beta_done) begin
                    next_st.conv_start = 1'b1;
                    next_st.phase = TRF_CONV;
                end
            end
            TRF_CONV: begin
                if (st.cfg[TRF_CFG_PWRDN]) begin
                    next_st.conv_abort = 1'b1;
                    next_st.phase = TRF_IDLE;
                end else if (conv.done) begin
                    next_st.phase = TRF_IDLE;
                end
            end
        endcase

        // Store result; a fault keeps the previous value
        if (store_ok) begin
            next_st.res_hi[st.chan] = fmt[15:8];
            next_st.res_lo[st.chan] = fmt[7:0];
            if (st.chan == TRF_CH_REMOTE) begin
                next_st.open_live = 1'b0;
            end
        end
        if (store_fault) begin
            next_st.open_live = 1'b1;
        end

        next_st.ol_act = next_ol;
        next_st.ol2_act = next_ol2;
        next_st.cnt = next_cnt;

        // Status clears on read, but a same-cycle event still lands
        if (bus.rd && bus.addr == TRF_ADDR_STATUS) begin
            next_st.status = 8'h00;
        end
        next_st.status[TRF_ST_LOC_HIGH] |= set_hi[0];
        next_st.status[TRF_ST_LOC_LOW] |= set_lo[0];
        next_st.status[TRF_ST_REM_HIGH] |= set_hi[1];
        next_st.status[TRF_ST_REM_LOW] |= set_lo[1];
        next_st.status[TRF_ST_OPEN] |= store_fault;

        // Alert latch: set by a qualified event, released by address read
        if (!st.cfg[TRF_CFG_FSEL] && !st.cfg[TRF_CFG_MASK]
            && (|qual || store_fault)) begin
            next_st.alert = 1'b1;
        end else if (alert_resp && next_st.status == 8'h00
            && !(|live) && !next_st.open_live) begin
            next_st.alert = 1'b0;
        end

        // Pins drive low only; no path from config reaches this one
        next_st.ol_oe_n = ~|next_ol;
        if (next_st.cfg[TRF_CFG_FSEL]) begin
            next_st.al_oe_n = ~|next_ol2;
        end else begin
            next_st.al_oe_n = ~(next_st.alert
                && !next_st.cfg[TRF_CFG_MASK]);
        end

        // Read data appear in the following cycle only
        if (bus.rd) begin
            unique case (bus.addr)
                TRF_ADDR_CFG: next_st.rdata = st.cfg;
                TRF_ADDR_HYST: next_st.rdata = st.hyst;
                TRF_ADDR_CONSEC: next_st.rdata = {6'h00, st.consec};
                TRF_ADDR_STATUS: next_st.rdata = st.status;
                TRF_ADDR_LOC_HI: next_st.rdata = st.res_hi[0];
                TRF_ADDR_LOC_LO: next_st.rdata = st.res_lo[0];
                TRF_ADDR_REM_HI: next_st.rdata = st.res_hi[1];
                TRF_ADDR_REM_LO: next_st.rdata = st.res_lo[1];
                TRF_ADDR_LOC_HLIM: next_st.rdata = st.hlim[0];
                TRF_ADDR_LOC_LLIM: next_st.rdata = st.llim[0];
                TRF_ADDR_REM_HLIM: next_st.rdata = st.hlim[1];
                TRF_ADDR_REM_LLIM: next_st.rdata = st.llim[1];
                TRF_ADDR_LOC_OLIM: next_st.rdata = st.olim[0];
                TRF_ADDR_REM_OLIM: next_st.rdata = st.olim[1];
                TRF_ADDR_PINS: next_st.rdata = {6'h00, alarm_pin_in,
                    over_limit_flag_in};
                default: next_st.rdata = 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    // Reset loads constants only, hysteresis among them
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= TRF_STATE_RST;
        end else begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign conv_start = st.conv_start;
    assign conv_chan = st.chan;
    assign beta_start = st.beta_start;
    assign conv_abort = st.conv_abort;
    assign over_limit_flag_o = 1'b0;
    assign over_limit_flag_oe_n = st.ol_oe_n;
    assign alarm_pin_o = 1'b0;
    assign alarm_pin_oe_n = st.al_oe_n;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    std_clamp_a: assert property (
        store_ok && !st.range_ext |=> st.res_hi[st.chan] <= 8'h7f)
        else $error("standard result above 7f");

    low_nibble_a: assert property (
        store_ok |=> st.res_lo[st.chan][3:0] == 4'h0
            && st.res_lo[st.chan][7:4] == $past(conv.temp[3:0])
            || st.res_lo[st.chan] == 8'h00)
        else $error("fraction byte malformed");

    range_hold_a: assert property (
        st.phase != TRF_IDLE && !next_st.conv_start && !next_st.beta_start
        |=> st.range_ext == $past(st.range_ext))
        else $error("range changed mid conversion");

    beta_first_a: assert property (
        st.conv_start && st.chan == TRF_CH_REMOTE
        |-> $past(st.phase) == TRF_BETA && $past(beta_done))
        else $error("remote conversion without range selection");

    fault_keep_a: assert property (
        store_fault |=> $stable(st.res_hi) && st.status[TRF_ST_OPEN])
        else $error("fault did not keep result or set open");

    over_pin_a: assert property (
        store_ok && hi > st.olim[st.chan] |=> !over_limit_flag_oe_n)
        else $error("over-limit flag not driven");

    hyst_release_a: assert property (
        st.ol_act[st.chan] && store_ok
        && hi > (st.olim[st.chan] > st.hyst ? 8'(st.olim[st.chan]
            - st.hyst) : 8'h00) |=> st.ol_act[$past(st.chan)])
        else $error("over-limit released inside hysteresis");

    mask_a: assert property (
        st.cfg[TRF_CFG_MASK] && !st.cfg[TRF_CFG_FSEL] |-> alarm_pin_oe_n)
        else $error("masked alert driven");

    consec_a: assert property (
        $rose(st.alert) |-> st.open_live || st.cnt[0] > {1'b0, st.consec}
            || st.cnt[1] > {1'b0, st.consec})
        else $error("alert before consecutive count");

    release_a: assert property (
        $fell(st.alert) |-> $past(alert_resp) && st.status == 8'h00)
        else $error("alert released without response read");

    shutdown_a: assert property (
        st.phase != TRF_IDLE && st.cfg[TRF_CFG_PWRDN]
        |=> st.phase == TRF_IDLE && st.conv_abort)
        else $error("shutdown did not abort");

    remote_fault_c: cover property (store_fault ##[1:20] alert_resp);
    alert_clear_c: cover property ($rose(st.alert) ##[1:200] $fell(st.alert));
    second_flag_c: cover property (st.cfg[TRF_CFG_FSEL] && !alarm_pin_oe_n);
    abort_c: cover property (st.conv_abort);

endmodule // trf_core

/* test/trf_fe_model.sv */
// Behavioural analog front end answering conversion and range requests
module trf_fe_model
    import trf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic conv_start,
    input wire logic beta_start,
    input wire logic conv_abort,
    input wire logic conv_chan,
    input wire logic signed [12:0] temp_loc,
    input wire logic signed [12:0] temp_rem,
    input wire logic fault_rem,
    input wire logic [3:0] lat,
    output trf_conv_t conv,
    output logic beta_done
);
    timeunit 1ns;
    timeprecision 1ps;

    logic busy;
    logic is_beta;
    logic [3:0] cnt;

    // One request in flight; an abort drops it with no answer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            is_beta <= 1'b0;
            cnt <= 4'h0;
            conv <= '0;
            beta_done <= 1'b0;
        end else begin
            conv.done <= 1'b0;
            conv.fault <= ~conv.fault;
            conv.temp <= ~conv.temp;
            beta_done <= 1'b0;
            if (conv_abort) begin
                busy <= 1'b0;
            end else if (conv_start || beta_start) begin
                busy <= 1'b1;
                is_beta <= beta_start;
                cnt <= lat;
            end else if (busy && cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else if (busy) begin
                // Data only valid beside done; it toggles otherwise
                busy <= 1'b0;
                beta_done <= is_beta;
                conv.done <= !is_beta;
                conv.fault <= !is_beta && conv_chan && fault_rem;
                conv.temp <= conv_chan ? temp_rem : temp_loc;
            end
        end
    end
endmodule // trf_fe_model

/* test/trf_core_tb.sv */
// Self-checking bench for the result format and alarm block
module trf_core_tb
    import trf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys;
    logic rst_n;
    trf_bus_t bus;
    logic [7:0] rdata;
    trf_conv_t conv;
    logic beta_done, alert_resp, conv_start, conv_chan, beta_start;
    logic conv_abort, ol_o, ol_oe_n, al_o, al_oe_n, ol_in, al_in;
    logic signed [12:0] t_loc, t_rem;
    logic f_rem, beta_seen = 1'b0, seen;
    logic [3:0] lat;
    logic [7:0] d;
    int mismatches, num_checks, n;
    logic [11:0] rv [11] = '{12'h000, 12'h10a, 12'h200, 12'h300, 12'h855,
        12'h900, 12'ha55, 12'hb00, 12'hc55, 12'hd55, 12'hf00};
    logic signed [12:0] corner [8] = '{-13'sd1024, -13'sd1, 13'sd0,
        13'sd2047, 13'sd2048, 13'sd3071, 13'sd4095, -13'sd1040};

    // Open-drain pins with pull-ups: released reads high
    assign ol_in = ol_oe_n ? 1'b1 : ol_o;
    assign al_in = al_oe_n ? 1'b1 : al_o;

    trf_core u_trf_core (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
        .rdata(rdata), .conv(conv), .beta_done(beta_done),
        .alert_resp(alert_resp), .conv_start(conv_start),
        .conv_chan(conv_chan), .beta_start(beta_start),
        .conv_abort(conv_abort), .over_limit_flag_in(ol_in),
        .over_limit_flag_o(ol_o), .over_limit_flag_oe_n(ol_oe_n),
        .alarm_pin_in(al_in), .alarm_pin_o(al_o), .alarm_pin_oe_n(al_oe_n));

    trf_fe_model u_trf_fe_model (.clk_sys(clk_sys), .rst_n(rst_n),
        .conv_start(conv_start), .beta_start(beta_start),
        .conv_abort(conv_abort), .conv_chan(conv_chan), .temp_loc(t_loc),
        .temp_rem(t_rem), .fault_rem(f_rem), .lat(lat), .conv(conv),
        .beta_done(beta_done));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic end_sim;
        if (mismatches == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] g, e, input string m);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic chk_bit(input logic g, e, input string m);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL %0t %s got %b exp %b", $time, m, g, e);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= v;
        @(posedge clk_sys);
        bus.wr <= 1'b0;
    endtask

    task automatic rdc(input logic [3:0] a, input logic [7:0] e,
        input string m);
        @(posedge clk_sys);
        bus.rd <= 1'b1;
        bus.addr <= a;
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1 chk_byte(rdata, e, m);
    endtask

    // Host read of the device address, then let the pin settle
    task automatic ack;
        @(posedge clk_sys);
        alert_resp <= 1'b1;
        @(posedge clk_sys);
        alert_resp <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    task automatic wait_ch(input logic ch);
        int k;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (!(conv.done && conv_chan == ch) && k < 500);
        if (k >= 500) begin
            mismatches++;
            $display("FAIL %0t no conversion", $time);
        end
        #1;
    endtask

    // Expected two-byte result; clamped values carry no fraction
    function automatic logic [15:0] fmt(input logic signed [12:0] t,
        input logic ext);
        int w;
        w = int'(t >>> 4) + (ext ? 64 : 0);
        if (w < 0) return 16'h0000;
        if (w > (ext ? 255 : 127)) return {(ext ? 8'hff : 8'h7f), 8'h00};
        return {w[7:0], t[3:0], 4'h0};
    endfunction

    task automatic cleanup;
        t_loc = 13'sd480;
        t_rem = 13'sd480;
        f_rem = 1'b0;
        wait_ch(0);
        wait_ch(1);
        // Clear stale flags first
        @(posedge clk_sys);
        bus.rd <= 1'b1;
        bus.addr <= TRF_ADDR_STATUS;
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        rdc(TRF_ADDR_STATUS, 8'h00, "status flush");
        ack;
        wait_ch(1);
    endtask

    // A remote conversion must be preceded by its range selection
    always @(posedge clk_sys) begin
        if (rst_n && beta_start) begin
            beta_seen <= 1'b1;
            chk_bit(conv_chan, 1'b1, "range chan");
        end
        if (rst_n && conv_start && conv_chan) begin
            chk_bit(beta_seen, 1'b1, "range first");
            beta_seen <= 1'b0;
        end
    end

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        #800_000;
        mismatches++;
        $display("FAIL %0t watchdog", $time);
        end_sim;
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [15:0] el, er;
        logic nx;
        bus = '0;
        alert_resp = 1'b0;
        rst_n = 1'b0;
        t_loc = 13'sd480;
        t_rem = 13'sd480;
        f_rem = 1'b0;
        lat = 4'h4;
        mismatches = 0;
        num_checks = 0;
        void'($urandom(25573));
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 11; i++) rdc(rv[i][11:8], rv[i][7:0], "reset");
        chk_bit(al_in, 1'b1, "alert idle");
        wait_ch(0);
        wait_ch(1);
        el = 16'h1e00;
        er = 16'h1e00;
        // Corners in both ranges, then random temperatures
        for (int i = 0; i < 24; i++) begin
            nx = (i < 16) ? i[3] : 1'($urandom_range(0, 1));
            lat = 4'($urandom_range(0, 8));
            wr(TRF_ADDR_CFG, {5'h0, nx, 2'h0});
            rdc(TRF_ADDR_LOC_HI, el[15:8], "kept hi");
            rdc(TRF_ADDR_REM_LO, er[7:0], "kept lo");
            t_loc = (i < 16) ? corner[i % 8] : 13'($urandom);
            t_rem = 13'($urandom);
            repeat (2) wait_ch(0);
            repeat (2) wait_ch(1);
            el = fmt(t_loc, nx);
            er = fmt(t_rem, nx);
            rdc(TRF_ADDR_LOC_HI, el[15:8], "loc hi");
            rdc(TRF_ADDR_LOC_LO, el[7:0], "loc lo");
            rdc(TRF_ADDR_REM_HI, er[15:8], "rem hi");
            rdc(TRF_ADDR_REM_LO, er[7:0], "rem lo");
        end
        wr(TRF_ADDR_CFG, 8'h80);
        cleanup;
        // Masked alert; over-limit flag then its hysteresis release
        for (int i = 0; i < 8; i++) begin
            if (i == 4) wr(TRF_ADDR_CFG, 8'ha0);
            n = (i % 4 == 0) ? 90 - i : (i % 4 == 3) ? 75 : 80 - i % 4;
            t_loc = 13'(n * 16);
            wait_ch(0);
            chk_bit(ol_in, i % 4 == 3, "flag pin");
            chk_bit(al_in, i < 4 || i == 7, "shared pin");
        end
        wr(TRF_ADDR_CFG, 8'h00);
        // Consecutive-violation filter and alert release conditions
        for (int i = 0; i < 5; i++) begin
            n = i % 4 + 1;
            wr(TRF_ADDR_LOC_LLIM, (i == 4) ? 8'h14 : 8'h00);
            wr(TRF_ADDR_CONSEC, 8'(n - 1));
            cleanup;
            t_loc = (i == 4) ? 13'sd160 : 13'sd1440;
            for (int k = 1; k <= n; k++) begin
                wait_ch(0);
                chk_bit(al_in, k < n, "alert count");
            end
            ack;
            chk_bit(al_in, 1'b0, "alert held");
            t_loc = 13'sd480;
            wait_ch(0);
            ack;
            chk_bit(al_in, 1'b0, "status set");
            rdc(TRF_ADDR_STATUS, (i == 4) ? 8'h20 : 8'h40, "status");
            ack;
            chk_bit(al_in, 1'b1, "alert freed");
        end
        // Remote open fault keeps the last good result
        t_rem = 13'sd640;
        wait_ch(1);
        wait_ch(1);
        f_rem = 1'b1;
        t_rem = 13'sd1584;
        wait_ch(1);
        f_rem = 1'b0;
        t_rem = 13'sd640;
        rdc(TRF_ADDR_REM_HI, 8'h28, "fault hold");
        chk_bit(al_in, 1'b0, "fault alert");
        rdc(TRF_ADDR_PINS, 8'h01, "pins");
        wait_ch(1);
        rdc(TRF_ADDR_STATUS, 8'h04, "open bit");
        ack;
        chk_bit(al_in, 1'b1, "fault freed");
        // Shutdown aborts the running conversion and halts starts
        lat = 4'hf;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (!(conv_start || beta_start) && n < 200);
        chk_bit(n < 200, 1'b1, "start");
        wr(TRF_ADDR_CFG, 8'h40);
        seen = 1'b0;
        repeat (4) @(posedge clk_sys) seen |= conv_abort;
        chk_bit(seen, 1'b1, "abort");
        seen = 1'b0;
        repeat (40) @(posedge clk_sys) seen |= conv_start | beta_start;
        chk_bit(seen, 1'b0, "halted");
        wr(TRF_ADDR_CFG, 8'h00);
        seen = 1'b0;
        repeat (4) @(posedge clk_sys) seen |= conv_start | beta_start;
        chk_bit(seen, 1'b1, "resumed");
        end_sim;
    end
endmodule // trf_core_tb
